// ### hdl/swm_defines.svh
// timing counts and command codes of the single-wire bus master
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH

// ***************************************************
// clock and microsecond tick
// ***************************************************
`define SWM_CLK_PERIOD_PS 5000
`define SWM_TICK_NS 1000
`define SWM_TICK_CYC ((`SWM_TICK_NS * 1000) / `SWM_CLK_PERIOD_PS)

// ***************************************************
// bus timing, in microseconds (one tick each)
// ***************************************************
`define SWM_T_W 10
`define SWM_RESET_LOW_US 500
`define SWM_RESET_LOW_MIN_US 480
`define SWM_RESET_LOW_MAX_US 960
`define SWM_RESET_HIGH_US 480
`define SWM_PRESENCE_SAMPLE_US 70
`define SWM_ONE_LOW_US 1
`define SWM_ZERO_LOW_US 60
`define SWM_SAMPLE_US 13
`define SWM_SLOT_US 70
`define SWM_SLOT_MAX_US 120
`define SWM_RECOVERY_US 5

// ***************************************************
// network-layer command codes and the read fill byte
// ***************************************************
`define SWM_CMD_SKIP 8'hcc
`define SWM_CMD_SEARCH 8'hf0
`define SWM_READ_FILL 8'hff

`endif

// ### hdl/swm_pkg.sv
// types of the single-wire bus master
package swm_pkg;

	// ***************************************************
	// sequencer states, one-hot
	// ***************************************************
	typedef enum logic [3:0] {
		SWM_IDLE     = 4'b0001,
		SWM_RST_LOW  = 4'b0010,
		SWM_RST_HIGH = 4'b0100,
		SWM_SLOT     = 4'b1000
	} swm_state_e;

	// ***************************************************
	// user operations
	// ***************************************************
	typedef enum logic [2:0] {
		SWM_OP_RESET   = 3'h0,
		SWM_OP_WRITE   = 3'h1,
		SWM_OP_READ    = 3'h2,
		SWM_OP_TRIPLET = 3'h3,
		SWM_OP_SKIP    = 3'h4,
		SWM_OP_SEARCH  = 3'h5
	} swm_op_e;

	// ***************************************************
	// whole state of the master
	// ***************************************************
	typedef struct packed {
		swm_state_e state;
		swm_op_e op;
		logic [7:0] div;
		logic [9:0] t;
		logic [7:0] sh;
		logic [2:0] bit_cnt;
		logic [1:0] phase;
		logic rbit;
		logic id_b;
		logic cmp_b;
		logic fail;
		logic present;
		logic push;
		logic [7:0] pdata;
	} swm_ctl_s;

endpackage : swm_pkg

// ### hdl/swm_fifo.sv
// small register fifo for the result stream
module swm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import swm_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ***************************************************
	// storage and pointers, one extra bit tells full from empty
	// ***************************************************
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} swm_fifo_s;

	swm_fifo_s st_r;
	swm_fifo_s st_nxt;
	logic full;
	logic empty;

	// flags from pointer compare; depth must be a power of two
	assign empty = (st_r.wptr == st_r.rptr);
	assign full = (st_r.wptr[AW] != st_r.rptr[AW]) && (st_r.wptr[AW-1:0] == st_r.rptr[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = st_r.mem[st_r.rptr[AW-1:0]];

	// next state
	always_comb begin
		st_nxt = st_r;
		if (in_valid && !full) begin
			st_nxt.mem[st_r.wptr[AW-1:0]] = in_data;
			st_nxt.wptr = st_r.wptr + 1'b1;
		end
		if (out_ready && !empty) begin
			st_nxt.rptr = st_r.rptr + 1'b1;
		end
	end

	// registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule // swm_fifo

// ### hdl/swm_master.sv
// single-wire bus master: reset/presence, bit slots, bytes and search triplets
// Notes on behaviour
// - skip code cch lets memory functions follow without the 64-bit identity
// - search f0h: per bit read id, read complement, then write chosen bit
// - the master runs one triplet per command; the user repeats it over all 64 bits, once per slave found
// - four signals: reset/presence, write 0, write 1, read; master starts all but presence
// - every transaction starts with the line held low at least 480 us; the master sends that reset only on SWM_OP_RESET, other ops start without one
// - reset low time stays at or below 960 us
// - nothing new starts until 480 us of reset high time have passed
// - every slot starts with the master driving the line low
// - a read slot pulls low at most 1 us, then samples inside the window
// - the idle bus is released high; never left low between operations
// - each byte goes out least significant bit first
`include "swm_defines.svh"
module swm_master #(
	// clk_sys cycles in one bus microsecond
	parameter int TICK_CYC = `SWM_TICK_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire swm_pkg::swm_op_e cmd_op,
	input wire logic [7:0] cmd_data,
	// result port
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [7:0] rsp_data,
	// bus pin, open drain
	input wire logic line_i,
	output logic line_o,
	output logic line_oe,
	// status
	output logic busy
);
	import swm_pkg::*;

	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

	swm_ctl_s st_r;
	swm_ctl_s st_nxt;
	logic fifo_in_ready;
	logic room;
	logic tick;
	logic cur_bit;
	logic [9:0] low_len;

	// ***************************************************
	// pin drive
	// ***************************************************
	// only ever pulls low, so a slave answer can override a released line
	assign line_o = 1'b0;
	assign cur_bit = (st_r.op == SWM_OP_TRIPLET && st_r.phase != 2'd2) ? 1'b1 : st_r.sh[0];
	assign low_len = cur_bit ? 10'(`SWM_ONE_LOW_US) : 10'(`SWM_ZERO_LOW_US);
	// drive during reset low and the front of each slot, released otherwise
	assign line_oe = (st_r.state == SWM_RST_LOW) ||
		(st_r.state == SWM_SLOT && st_r.t < low_len);
	assign tick = (st_r.div == TICK_LAST);
	// a push still on its way to the fifo takes the last free word
	assign room = fifo_in_ready && !st_r.push;
	assign cmd_ready = (st_r.state == SWM_IDLE) && room;
	assign busy = (st_r.state != SWM_IDLE);

	// ***************************************************
	// sequencer
	// ***************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.push = 1'b0;
		st_nxt.div = tick ? 8'h00 : st_r.div + 8'h01;
		if (tick) begin
			st_nxt.t = st_r.t + 10'h001;
		end
		unique case (st_r.state)
			SWM_IDLE: begin
				st_nxt.div = 8'h00;
				st_nxt.t = '0;
				// one job at a time, taken only with room for its result
				if (cmd_valid && room) begin
					st_nxt.op = cmd_op;
					st_nxt.bit_cnt = 3'h0;
					st_nxt.phase = 2'd0;
					st_nxt.fail = 1'b0;
					st_nxt.sh = cmd_data;
					st_nxt.state = SWM_SLOT;
					unique case (cmd_op)
						SWM_OP_RESET: st_nxt.state = SWM_RST_LOW;
						SWM_OP_READ: st_nxt.sh = `SWM_READ_FILL;
						SWM_OP_SKIP: st_nxt.sh = `SWM_CMD_SKIP;
						SWM_OP_SEARCH: st_nxt.sh = `SWM_CMD_SEARCH;
						SWM_OP_TRIPLET: st_nxt.sh = {7'h00, cmd_data[0]};
						default: st_nxt.sh = cmd_data;
					endcase
				end
			end
			SWM_RST_LOW: begin
				// 500 us sits inside the legal 480..960 us window
				if (tick && st_r.t == 10'(`SWM_RESET_LOW_US - 1)) begin
					st_nxt.state = SWM_RST_HIGH;
					st_nxt.t = '0;
					st_nxt.present = 1'b0;
				end
			end
			SWM_RST_HIGH: begin
				// 70 us after release a presence pulse must still be low
				if (tick && st_r.t == 10'(`SWM_PRESENCE_SAMPLE_US - 1)) begin
					st_nxt.present = !line_i;
				end
				if (tick && st_r.t == 10'(`SWM_RESET_HIGH_US - 1)) begin
					st_nxt.state = SWM_IDLE;
					st_nxt.push = 1'b1;
					st_nxt.pdata = {7'h00, st_r.present};
				end
			end
			SWM_SLOT: begin
				// sampling at 13 us sits inside the 15 us valid window
				if (tick && st_r.t == 10'(`SWM_SAMPLE_US - 1)) begin
					st_nxt.rbit = line_i;
				end
				if (tick && st_r.t == 10'(`SWM_SLOT_US + `SWM_RECOVERY_US - 1)) begin
					st_nxt.t = '0;
					if (st_r.op == SWM_OP_TRIPLET) begin
						unique case (st_r.phase)
							2'd0: begin
								st_nxt.id_b = st_r.rbit;
								st_nxt.phase = 2'd1;
							end
							2'd1: begin
								st_nxt.cmp_b = st_r.rbit;
								st_nxt.phase = 2'd2;
								// disagreeing pair fixes the direction
								if (st_r.id_b != st_r.rbit) begin
									st_nxt.sh[0] = st_r.id_b;
								end
								// both ones: nobody left, skip the write
								if (st_r.id_b && st_r.rbit) begin
									st_nxt.fail = 1'b1;
									st_nxt.state = SWM_IDLE;
									st_nxt.push = 1'b1;
									st_nxt.pdata = {4'h0, 1'b1, st_r.sh[0], 2'b11};
								end
							end
							default: begin
								st_nxt.state = SWM_IDLE;
								st_nxt.push = 1'b1;
								st_nxt.pdata = {4'h0, st_r.fail, st_r.sh[0], st_r.cmp_b,
									st_r.id_b};
							end
						endcase
					end else begin
						// lsb first out, sampled bit in from the top
						st_nxt.sh = {st_r.rbit, st_r.sh[7:1]};
						st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
						if (st_r.bit_cnt == 3'h7) begin
							st_nxt.state = SWM_IDLE;
							st_nxt.push = 1'b1;
							st_nxt.pdata = {st_r.rbit, st_r.sh[7:1]};
						end
					end
				end
			end
		endcase
	end

	// registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_r <= '{state: SWM_IDLE, op: SWM_OP_RESET, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ***************************************************
	// result buffer
	// ***************************************************
	swm_fifo #(
		.WIDTH(8),
		.DEPTH(4)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(st_r.push),
		.in_ready(fifo_in_ready),
		.in_data(st_r.pdata),
		.out_valid(rsp_valid),
		.out_ready(rsp_ready),
		.out_data(rsp_data)
	);

	// ***************************************************
	// checks
	// ***************************************************
	logic [19:0] low_cyc;
	logic [19:0] high_cyc;
	logic [7:0] cap_data;
	logic first_low;
	logic low_was_rst;

	// helper counters of continuous drive and release time
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			low_cyc <= '0;
			high_cyc <= '0;
			cap_data <= '0;
			first_low <= 1'b0;
			low_was_rst <= 1'b0;
		end else begin
			low_cyc <= line_oe ? low_cyc + 20'h00001 : 20'h00000;
			high_cyc <= line_oe ? 20'h00000 : high_cyc + 20'h00001;
			low_was_rst <= (st_r.state == SWM_RST_LOW);
			if (cmd_valid && cmd_ready) begin
				cap_data <= cmd_data;
				first_low <= (cmd_op == SWM_OP_WRITE);
			end else if ($fell(line_oe)) begin
				first_low <= 1'b0;
			end
		end
	end

	a_rst_low_min: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(line_oe) && low_was_rst |-> low_cyc >= 20'(`SWM_RESET_LOW_MIN_US * TICK_CYC))
		else $error("reset low too short");
	a_rst_low_max: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(line_oe) && low_was_rst |-> low_cyc <= 20'(`SWM_RESET_LOW_MAX_US * TICK_CYC))
		else $error("reset low too long");
	a_rst_high_min: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(st_r.state) == SWM_RST_HIGH && st_r.state != SWM_RST_HIGH |->
		high_cyc >= 20'(`SWM_RESET_HIGH_US * TICK_CYC))
		else $error("reset high interval cut short");
	a_slot_low_max: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(line_oe) && !low_was_rst |-> low_cyc <= 20'(`SWM_SLOT_MAX_US * TICK_CYC))
		else $error("slot low too long");
	a_one_low_short: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(line_oe) && !low_was_rst && cur_bit |-> low_cyc == 20'(TICK_CYC))
		else $error("read or one slot low not 1 us");
	a_slot_recovery: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(line_oe) && st_r.state == SWM_SLOT |->
		high_cyc >= 20'(`SWM_RECOVERY_US * TICK_CYC))
		else $error("slot recovery too short");
	a_idle_released: assert property (@(posedge clk_sys) disable iff (!rst_b)
		st_r.state == SWM_IDLE |-> !line_oe && !line_o)
		else $error("line driven while idle");
	a_slot_falls: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(st_r.state == SWM_SLOT) |-> line_oe ##1 line_oe)
		else $error("slot without master low");
	a_lsb_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(line_oe) && first_low |->
		(cap_data[0] ? low_cyc < 20'(`SWM_ZERO_LOW_US * TICK_CYC) :
		low_cyc >= 20'(`SWM_ZERO_LOW_US * TICK_CYC)))
		else $error("first bit is not the lsb");
	a_skip_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cmd_valid && cmd_ready && cmd_op == SWM_OP_SKIP |=> st_r.sh == 8'hcc)
		else $error("skip code wrong");
	a_triplet_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
		st_r.push && st_r.op == SWM_OP_TRIPLET && (st_r.pdata[0] != st_r.pdata[1]) |->
		st_r.pdata[2] == st_r.pdata[0] && !st_r.pdata[3])
		else $error("search direction ignores id bit");
	a_fail_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
		st_r.push && st_r.op == SWM_OP_TRIPLET && st_r.pdata[0] && st_r.pdata[1] |->
		st_r.pdata[3])
		else $error("search fail flag missing");

endmodule // swm_master

// ### dv/swm_slave_model.sv
// behavioural slave token on the single-wire line, timed in bus microseconds from each fall
module swm_slave_model #(
	parameter logic [63:0] ID = 64'h5,
	parameter logic [7:0] RD_BYTE = 8'h6b,
	// ns per bus microsecond, matching the bench's 10-cycle tick at 5 ns
	parameter int US = 50,
	parameter int PW = 20,
	parameter int HOLD = 15
) (
	// bus level and presence of the token
	input wire logic line,
	input wire logic en,
	output logic pull,
	// last byte taken, rom command or memory byte
	output logic [7:0] got_byte
);
	timeunit 1ns;
	timeprecision 1ps;

	int mode; // 0 out of play, 1 rom byte, 2 memory byte, 3 memory read, 4 search
	int bcnt;
	int step;
	logic b;
	logic [7:0] sh;
	longint t0;

	// a zero is a pull from the fall, held at least to the end of the valid window; a one leaves the line
	task automatic send_bit(input logic v);
		if (!v) begin
			pull = 1'b1;
			#(HOLD * US);
			pull = 1'b0;
		end
	endtask

	// sample well inside the write-zero low time, well after a write-one ends
	task automatic take_bit();
		#(30 * US);
		b = line;
	endtask

	// one slot per master fall; a long low is a reset, answered with presence
	initial begin
		pull = 1'b0;
		got_byte = 8'h00;
		mode = 0;
		bcnt = 0;
		step = 0;
		sh = 8'h00;
		t0 = 0;
		forever begin
			@(negedge line);
			t0 = $time;
			if (en) begin
				case (mode)
					1, 2: begin
						take_bit();
						sh = {b, sh[7:1]};
						bcnt++;
						if (bcnt == 8) begin
							bcnt = 0;
							got_byte = sh;
							mode = (mode == 2) ? 3 : (sh == 8'hcc) ? 2 : (sh == 8'hf0) ? 4 : 0;
						end
					end
					3: begin
						send_bit(RD_BYTE[bcnt]);
						bcnt = (bcnt + 1) % 8;
					end
					4: begin
						if (step == 2) begin
							take_bit();
							if (b !== ID[bcnt]) mode = 0;
							bcnt++;
						end else begin
							send_bit(ID[bcnt] ^ step[0]);
						end
						step = (step + 1) % 3;
					end
					default: ;
				endcase
			end
			wait (line === 1'b1);
			if (en && ($time - t0) >= 480 * US) begin
				#(PW * US);
				pull = 1'b1;
				#(120 * US);
				pull = 1'b0;
				mode = 1;
				bcnt = 0;
				step = 0;
			end
		end
	end
endmodule // swm_slave_model

// ### dv/testbench.sv
// self-checking bench of the single-wire bus master against two slave models
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import swm_pkg::*;

	// ***************************************************
	// signals, line and instances
	// ***************************************************
	// a 10-cycle bus microsecond keeps the run short; master and bench timing scale with it, the slave models keep US at 50
	localparam int TICK = 10;
	localparam int US = TICK * 5; // ns per bus microsecond at the 5 ns clock
	localparam int LIM = 20000;
	logic clk_sys = 1'b0;
	logic rst_b, cmd_valid, rsp_ready, slv_en, cmd_ready, rsp_valid, line_oe, busy, pull_a, pull_b;
	swm_op_e cmd_op;
	logic [7:0] cmd_data, rsp_data, got_a;
	wire logic line;
	int n_mismatch = 0;
	int checks_done = 0;
	longint t_rise = 0;
	longint t_rend = 0;
	logic last_rst = 1'b0;

	always #2.5 clk_sys = ~clk_sys;
	// open drain: any pull wins, the pull-up gives the idle high
	assign line = !(line_oe | pull_a | pull_b);

	swm_master #(.TICK_CYC(TICK)) swm_master_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .line_i(line),
		.line_o(), .line_oe(line_oe), .busy(busy));
	// ids differ at bits 1 and 2; prompt and slow presence, short and long read hold
	// slave_a runs on the model defaults: id 5, read byte 6b, presence 20, hold 15
	swm_slave_model slave_a (
		.line(line), .en(slv_en), .pull(pull_a), .got_byte(got_a));
	swm_slave_model #(.ID(64'h3), .RD_BYTE(8'hde), .PW(50), .HOLD(25)) slave_b (
		.line(line), .en(slv_en), .pull(pull_b), .got_byte());

	// ***************************************************
	// report, compare and handshake tasks
	// ***************************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ck_span(input longint d, input longint lo, input longint hi);
		checks_done++;
		if (d < lo || d > hi) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, d, lo, hi);
		end
	endtask

	// one clock edge of a bounded wait; running out ends the run
	task automatic guard(inout int n);
		@(posedge clk_sys);
		n++;
		if (n > LIM) begin
			n_mismatch++;
			test_done();
		end
	endtask

	task automatic send_cmd(input swm_op_e op, input logic [7:0] d);
		int n = 0;
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		do guard(n); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
	endtask

	// the extra edge keeps two pops from reassigning ready in one time step
	task automatic get_rsp(input logic [7:0] exp);
		int n = 0;
		logic [7:0] got;
		rsp_ready <= 1'b1;
		do guard(n); while (rsp_valid !== 1'b1);
		got = rsp_data;
		rsp_ready <= 1'b0;
		@(posedge clk_sys);
		cmp8(got, exp);
	endtask

	task automatic wait_idle();
		int n = 0;
		do guard(n); while (busy !== 1'b0);
	endtask

	// wire timing of every low pulse that the master makes
	always @(posedge line_oe) begin
		if (rst_b === 1'b1 && t_rise > 0) begin
			if (last_rst) ck_span($time - t_rend, 480 * US, 64'h7fffffff);
			else ck_span($time - t_rise, 60 * US, 64'h7fffffff);
		end
		t_rise = $time;
	end

	always @(negedge line_oe) begin
		if (rst_b === 1'b1) begin
			last_rst = ($time - t_rise) >= 480 * US;
			if (last_rst) ck_span($time - t_rise, 480 * US, 960 * US);
			else ck_span($time - t_rise, 1 * US, 120 * US);
			t_rend = $time;
		end
	end

	// ***************************************************
	// scenarios
	// ***************************************************
	// no token on the line: reset reports nobody, a triplet reads two ones and fails
	task automatic t_absent();
		send_cmd(SWM_OP_RESET, 8'h00);
		get_rsp(8'h00);
		send_cmd(SWM_OP_TRIPLET, 8'h00);
		get_rsp(8'h0b);
	endtask

	// skip, a memory byte out, then a read where both tokens collide as wired-and
	task automatic t_skip_rw();
		slv_en <= 1'b1;
		send_cmd(SWM_OP_RESET, 8'h00);
		get_rsp(8'h01);
		send_cmd(SWM_OP_SKIP, 8'h00);
		get_rsp(8'hcc);
		send_cmd(SWM_OP_WRITE, 8'h0f);
		get_rsp(8'h0f);
		cmp8(got_a, 8'h0f);
		send_cmd(SWM_OP_READ, 8'h00);
		get_rsp(8'h4a);
	endtask

	// search with results left in the fifo until it refuses, then drain
	task automatic t_search();
		int i;
		send_cmd(SWM_OP_RESET, 8'h00);
		wait_idle();
		send_cmd(SWM_OP_SEARCH, 8'h00);
		wait_idle();
		send_cmd(SWM_OP_TRIPLET, 8'h00);
		wait_idle();
		send_cmd(SWM_OP_TRIPLET, 8'h00);
		wait_idle();
		cmd_valid <= 1'b1;
		cmd_op <= SWM_OP_TRIPLET;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			cmp8({7'h00, cmd_ready}, 8'h00);
		end
		cmd_valid <= 1'b0;
		get_rsp(8'h01);
		get_rsp(8'hf0);
		get_rsp(8'h05);
		get_rsp(8'h00);
		send_cmd(SWM_OP_TRIPLET, 8'h00);
		get_rsp(8'h05);
		send_cmd(SWM_OP_TRIPLET, 8'h01);
		get_rsp(8'h02);
	endtask

	// main sequence
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = SWM_OP_RESET;
		cmd_data = 8'h00;
		rsp_ready = 1'b0;
		slv_en = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_absent();
		t_skip_rw();
		t_search();
		test_done();
	end
endmodule // testbench
